// *** rtl/buf_status_pkg.sv ***
// constants for the message-buffer bookkeeping block
// assumes a 16-bit register port and a 10 MHz module clock
// Summary of operation
// - mask bit one compares extended id bit
// - received write sets buffer full flag
// - software clears full flags; reset zero
// - write into full buffer sets overflow
// - direction bit one makes transmit buffer
// - low byte even buffer, high odd
// - aborted status set by abort
// - lost arbitration status set on loss
// - bus error status set on error
// - send request set clears three statuses
// - send request cleared after successful send
// - writing zero while pending requests abort
// - remote frame sets request when enabled
// - two-bit priority, 11 highest
// - id word bits 12:2 hold standard id
// - id word bit 1 remote request
// - id word bit 0 extended id flag
// - buffer words live in shared memory
// - id word bits 15:13 read zero
package buf_status_pkg;
  localparam logic [4:0] addr_mask_ext = 5'h00;
  localparam logic [4:0] addr_full_lo = 5'h01;
  localparam logic [4:0] addr_full_hi = 5'h02;
  localparam logic [4:0] addr_ovf_lo = 5'h03;
  localparam logic [4:0] addr_ovf_hi = 5'h04;
  localparam logic [4:0] addr_ctrl_base = 5'h08;
  localparam logic [4:0] addr_offer = 5'h0c;
  localparam logic [4:0] addr_id_port = 5'h0d;
  localparam logic [4:0] addr_id_data = 5'h0e;
  localparam int bit_dir = 7;
  localparam int bit_abt = 6;
  localparam int bit_larb = 5;
  localparam int bit_err = 4;
  localparam int bit_req = 3;
  localparam int bit_rtr = 2;
  localparam int pri_lsb = 0;
  localparam int id_std_lsb = 2;
  localparam int id_std_msb = 12;
  localparam int id_srr = 1;
  localparam int id_ide = 0;
  localparam logic [15:0] id_impl_mask = 16'h1fff;
  localparam logic [15:0] flags_reset = 16'h0000;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [15:0] mask_reset = 16'h0000;
endpackage

// *** rtl/id_word_ram.sv ***
// shared-memory store of the standard identifier word per buffer
// assumes one write or one read port access per cycle
`timescale 1ns/10ps
module id_word_ram import buf_status_pkg::*; #(
  parameter int depth = 32
) (
  // clock
  input wire logic clk,
  // write side
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [15:0] wr_data,
  // read side
  input wire logic [4:0] rd_addr,
  output logic [15:0] rd_data
);
  logic [12:0] mem [depth];
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data[12:0];
    end
    rd_data <= {3'h0, mem[rd_addr]};
  end
endmodule

// *** rtl/buf_status.sv ***
// buffer full/overflow flags, buffer pair control and id word store
// assumes protocol engine pulses come from logic on the same clock
`timescale 1ns/10ps
module buf_status import buf_status_pkg::*; #(
  parameter int buffers = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // receive side events
  input wire logic rx_write,
  input wire logic [4:0] rx_buffer,
  input wire logic rx_remote,
  input wire logic [2:0] rx_remote_buffer,
  // transmit side events
  input wire logic tx_done,
  input wire logic tx_aborted,
  input wire logic tx_lost_arb,
  input wire logic tx_bus_error,
  input wire logic [2:0] tx_buffer,
  // to the protocol engine
  output logic [15:0] ext_id_bits,
  output logic tx_pending,
  output logic [2:0] tx_offer,
  output logic [7:0] abort_request
);
  initial begin
    if (buffers != 8) begin
      $error("buf_status supports exactly 8 control buffers");
    end
  end
  ////////////////////////////////////////////////////////////////////
  logic [31:0] buffer_full_flag;
  logic [31:0] buffer_overflow_flag;
  logic [7:0] ctrl [8];
  logic [4:0] id_ptr;
  logic [15:0] ram_rd;
  logic rd_id_q;
  logic [15:0] next_rdata;
  logic [31:0] rx_hit;
  logic [31:0] full_clr;
  logic [31:0] ovf_clr;
  wire wr_mask = wr && addr == addr_mask_ext;
  wire wr_full_lo = wr && addr == addr_full_lo;
  wire wr_full_hi = wr && addr == addr_full_hi;
  wire wr_ovf_lo = wr && addr == addr_ovf_lo;
  wire wr_ovf_hi = wr && addr == addr_ovf_hi;
  wire ctrl_sel = addr[4:2] == addr_ctrl_base[4:2];
  wire wr_ctrl = wr && ctrl_sel;
  wire [1:0] ctrl_word = addr[1:0];
  wire wr_id_ptr = wr && addr == addr_id_port;
  wire wr_id = wr && addr == addr_id_data;
  ////////////////////////////////////////////////////////////////////
  // receive flags
  assign rx_hit = rx_write ? (32'h1 << rx_buffer) : 32'h0;
  // writing zero clears, writing one is ignored
  assign full_clr = {wr_full_hi ? ~wdata : 16'h0, wr_full_lo ? ~wdata : 16'h0};
  assign ovf_clr = {wr_ovf_hi ? ~wdata : 16'h0, wr_ovf_lo ? ~wdata : 16'h0};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buffer_full_flag <= {flags_reset, flags_reset};
      buffer_overflow_flag <= {flags_reset, flags_reset};
    end else begin
      // set wins over a clear in the same cycle
      buffer_full_flag <= (buffer_full_flag & ~full_clr) | rx_hit;
      buffer_overflow_flag <= (buffer_overflow_flag & ~ovf_clr) |
                              (rx_hit & buffer_full_flag);
    end
  end
  ////////////////////////////////////////////////////////////////////
  // extended mask word: one bit per compared identifier bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_id_bits <= mask_reset;
    end else if (wr_mask) begin
      ext_id_bits <= wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // buffer pair control, even buffer in low byte, odd in high
  function automatic logic [7:0] next_ctrl(input logic [7:0] cur, input logic sw_wr,
      input logic [7:0] sw, input logic remote, input logic done, input logic abt,
      input logic larb, input logic err);
    logic [7:0] n;
    logic req_set;
    n = cur;
    req_set = 1'b0;
    if (sw_wr) begin
      n[bit_dir] = sw[bit_dir];
      n[bit_rtr] = sw[bit_rtr];
      n[pri_lsb +: 2] = sw[pri_lsb +: 2];
      n[bit_req] = sw[bit_req];
      req_set = sw[bit_req] && !cur[bit_req];
    end
    if (remote && cur[bit_rtr]) begin
      n[bit_req] = 1'b1;
      req_set = req_set || !cur[bit_req];
    end
    if (done) begin
      n[bit_req] = 1'b0;
      n[bit_abt] = 1'b0;
    end
    if (abt) begin
      n[bit_abt] = 1'b1;
      n[bit_req] = 1'b0;
    end
    if (larb) begin
      n[bit_larb] = 1'b1;
    end
    if (err) begin
      n[bit_err] = 1'b1;
    end
    if (req_set) begin
      n[bit_abt] = 1'b0;
      n[bit_larb] = 1'b0;
      n[bit_err] = 1'b0;
    end
    return n;
  endfunction
  logic [7:0] abort_hit;
  for (genvar b = 0; b < 8; b++) begin : g_ctrl
    wire sw_wr = wr_ctrl && ctrl_word == 2'(b / 2);
    wire [7:0] sw = (b % 2 == 1) ? wdata[15:8] : wdata[7:0];
    wire on_tx = tx_buffer == 3'(b);
    assign abort_hit[b] = sw_wr && ctrl[b][bit_req] && !sw[bit_req];
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        ctrl[b] <= ctrl_reset;
      end else begin
        ctrl[b] <= next_ctrl(ctrl[b], sw_wr, sw,
                             rx_remote && rx_remote_buffer == 3'(b),
                             tx_done && on_tx, tx_aborted && on_tx,
                             tx_lost_arb && on_tx, tx_bus_error && on_tx);
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      abort_request <= 8'h00;
    end else begin
      abort_request <= abort_hit;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // transmit arbitration: highest priority, lowest index on ties
  logic [2:0] best;
  logic best_valid;
  logic [1:0] best_pri;
  always_comb begin
    best = 3'h0;
    best_valid = 1'b0;
    best_pri = 2'h0;
    for (int b = 0; b < 8; b++) begin
      if (ctrl[b][bit_dir] && ctrl[b][bit_req] &&
          (!best_valid || ctrl[b][pri_lsb +: 2] > best_pri)) begin
        best = 3'(b);
        best_valid = 1'b1;
        best_pri = ctrl[b][pri_lsb +: 2];
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_pending <= 1'b0;
      tx_offer <= 3'h0;
    end else begin
      tx_pending <= best_valid;
      tx_offer <= best;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // identifier word store, reached through a pointer and data port
  function automatic logic [15:0] pack_id(input logic [10:0] std, input logic srr,
      input logic ide);
    pack_id = {3'h0, std, srr, ide};
  endfunction
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      id_ptr <= 5'h00;
    end else if (wr_id_ptr) begin
      id_ptr <= wdata[4:0];
    end
  end
  id_word_ram #(.depth(32)) u_ram (
    .clk(clk),
    .wr_en(wr_id),
    .wr_addr(id_ptr),
    .wr_data(pack_id(wdata[id_std_msb:id_std_lsb], wdata[id_srr], wdata[id_ide])),
    .rd_addr(id_ptr),
    .rd_data(ram_rd)
  );
  ////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  always_comb begin
    next_rdata = 16'h0000;
    if (ctrl_sel) begin
      next_rdata = {ctrl[{ctrl_word, 1'b1}], ctrl[{ctrl_word, 1'b0}]};
    end else begin
      case (addr)
        addr_mask_ext: next_rdata = ext_id_bits;
        addr_full_lo: next_rdata = buffer_full_flag[15:0];
        addr_full_hi: next_rdata = buffer_full_flag[31:16];
        addr_ovf_lo: next_rdata = buffer_overflow_flag[15:0];
        addr_ovf_hi: next_rdata = buffer_overflow_flag[31:16];
        addr_offer: next_rdata = {12'h000, tx_pending, tx_offer};
        addr_id_port: next_rdata = {11'h000, id_ptr};
        default: next_rdata = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
      rd_id_q <= 1'b0;
    end else begin
      rd_id_q <= 1'b0;
      if (rd) begin
        rdata <= next_rdata;
        rd_id_q <= addr == addr_id_data;
      end
    end
  end
  // the id data read returns zero; the ram output register only feeds id_read_hold
  ////////////////////////////////////////////////////////////////////
  wire [15:0] id_read_value = rd_id_q ? (ram_rd & id_impl_mask) : 16'h0000;
  logic [15:0] id_read_hold;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      id_read_hold <= 16'h0000;
    end else begin
      id_read_hold <= id_read_value;
    end
  end
  ////////////////////////////////////////////////////////////////////
  full_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    rx_write |=> buffer_full_flag[$past(rx_buffer)]) else $error("full flag not set");
  ovf_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    rx_write && buffer_full_flag[rx_buffer] |=> buffer_overflow_flag[$past(rx_buffer)])
    else $error("overflow not set");
  ovf_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
    rx_write && !buffer_full_flag[rx_buffer] && !buffer_overflow_flag[rx_buffer]
    |=> !buffer_overflow_flag[$past(rx_buffer)]) else $error("false overflow");
  flag_one_a: assert property (@(posedge clk) disable iff (!reset_n)
    !rx_write |=> (buffer_full_flag & ~$past(buffer_full_flag)) == 32'h0)
    else $error("full flag rose without a receive");
  req_clr_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_ctrl && ctrl_word == 2'h0 && wdata[bit_req] && !ctrl[0][bit_req] && !tx_done
    |=> ctrl[0][bit_req] && !ctrl[0][bit_abt] && !ctrl[0][bit_larb] && !ctrl[0][bit_err])
    else $error("status not cleared on request");
  done_a: assert property (@(posedge clk) disable iff (!reset_n)
    tx_done && !wr_ctrl && !rx_remote |=> !ctrl[$past(tx_buffer)][bit_req])
    else $error("request not cleared after send");
  abort_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_ctrl && ctrl_word == 2'h0 && ctrl[0][bit_req] && !wdata[bit_req]
    |=> abort_request[0]) else $error("abort not raised");
  remote_a: assert property (@(posedge clk) disable iff (!reset_n)
    rx_remote && ctrl[rx_remote_buffer][bit_rtr] && !tx_done && !tx_aborted && !wr_ctrl
    |=> ctrl[$past(rx_remote_buffer)][bit_req]) else $error("remote answer missing");
  offer_a: assert property (@(posedge clk) disable iff (!reset_n)
    tx_pending |-> ctrl[tx_offer][bit_dir] || $changed(ctrl[tx_offer]))
    else $error("offer is not a transmit buffer");
endmodule

// *** tb/can_engine_model.sv ***
// far-side model: protocol engine and bus outcome for offered buffers
// assumes design outputs are registered on clk
`timescale 1ns/10ps
module can_engine_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // from the design
  input wire logic tx_pending,
  input wire logic [2:0] tx_offer,
  input wire logic [7:0] abort_request,
  // bus outcome set by the bench: 0 busy, 1 sent, 2 lost, 3 error
  input wire logic [1:0] outcome,
  // to the design
  output logic tx_done,
  output logic tx_aborted,
  output logic tx_lost_arb,
  output logic tx_bus_error,
  output logic [2:0] tx_buffer
);
  logic [2:0] cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {tx_done, tx_aborted, tx_lost_arb, tx_bus_error} <= 4'h0;
      tx_buffer <= 3'h0;
      cnt <= 3'h0;
    end else begin
      {tx_done, tx_aborted, tx_lost_arb, tx_bus_error} <= 4'h0;
      tx_buffer <= ~tx_buffer;
      cnt <= tx_pending ? cnt + 3'h1 : 3'h0;
      if (|abort_request) begin
        tx_aborted <= 1'b1;
        for (int i = 0; i < 8; i++) begin
          if (abort_request[i]) tx_buffer <= 3'(i);
        end
      end else if (cnt == 3'h7 && outcome != 2'h0) begin
        tx_done <= (outcome == 2'h1);
        tx_lost_arb <= (outcome == 2'h2);
        tx_bus_error <= (outcome == 2'h3);
        tx_buffer <= tx_offer;
        cnt <= 3'h0;
      end
    end
  end
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the buffer status block
// assumes the engine model on the transmit side
`timescale 1ns/10ps
module testbench;
  import buf_status_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic rx_write = 1'b0, rx_remote = 1'b0;
  logic [4:0] addr = 5'h00, rx_buffer = 5'h00, b;
  logic [15:0] wdata = 16'h0000, rdata, ext_id_bits, v;
  logic [2:0] rx_remote_buffer = 3'h0, tx_buffer, tx_offer;
  logic [1:0] outcome = 2'h0, pa, pb;
  logic tx_done, tx_aborted, tx_lost_arb, tx_bus_error, tx_pending;
  logic [7:0] abort_request, st;
  logic [31:0] fe = 32'h0, oe = 32'h0;
  int fails = 0, n_checks = 0;
  always #50 clk = ~clk;
  buf_status dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rx_write(rx_write), .rx_buffer(rx_buffer),
    .rx_remote(rx_remote), .rx_remote_buffer(rx_remote_buffer), .tx_done(tx_done),
    .tx_aborted(tx_aborted), .tx_lost_arb(tx_lost_arb), .tx_bus_error(tx_bus_error),
    .tx_buffer(tx_buffer), .ext_id_bits(ext_id_bits), .tx_pending(tx_pending),
    .tx_offer(tx_offer), .abort_request(abort_request));
  can_engine_model engine (.clk(clk), .reset_n(reset_n), .tx_pending(tx_pending),
    .tx_offer(tx_offer), .abort_request(abort_request), .outcome(outcome),
    .tx_done(tx_done), .tx_aborted(tx_aborted), .tx_lost_arb(tx_lost_arb),
    .tx_bus_error(tx_bus_error), .tx_buffer(tx_buffer));
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] ctl(input logic d, r, q, input logic [1:0] p);
    return {d, 3'h0, q, r, p};
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    check(rdata, exp);
  endtask
  task automatic ev(input logic rem, input logic [4:0] n);
    rx_buffer <= n;
    rx_remote_buffer <= n[2:0];
    rx_write <= ~rem;
    rx_remote <= rem;
    @(posedge clk);
    rx_write <= 1'b0;
    rx_remote <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_pend(input logic lvl);
    int i;
    for (i = 0; i < 200 && tx_pending !== lvl; i++) @(posedge clk);
    if (i == 200) begin
      fails++;
      complete_run();
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    v = 16'($urandom(32'he3e3f95d));
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++) rchk(addr_mask_ext + 5'(i), 16'h0000);
    rchk(addr_ctrl_base, 16'h0000);
    $display("reset test done");
    v = 16'($urandom);
    wreg(addr_mask_ext, v);
    rchk(addr_mask_ext, v);
    check(ext_id_bits, v);
    $display("mask test done");
    for (int i = 0; i < 14; i++) begin
      b = (i < 2) ? 5'h1f : 5'($urandom_range(31));
      ev(1'b0, b);
      oe[b] = oe[b] | fe[b];
      fe[b] = 1'b1;
    end
    rchk(addr_full_lo, fe[15:0]);
    rchk(addr_full_hi, fe[31:16]);
    rchk(addr_ovf_lo, oe[15:0]);
    rchk(addr_ovf_hi, oe[31:16]);
    wreg(addr_full_lo, 16'hffff);
    rchk(addr_full_lo, fe[15:0]);
    wreg(addr_full_hi, 16'h7fff);
    fe[31] = 1'b0;
    rchk(addr_full_hi, fe[31:16]);
    wreg(addr_ovf_hi, 16'h0000);
    rchk(addr_ovf_hi, 16'h0000);
    $display("flag test done");
    pa = 2'($urandom);
    pb = 2'($urandom);
    wreg(addr_ctrl_base + 5'h1, {ctl(1, 0, 1, pb), ctl(1, 0, 1, pa)});
    wait_pend(1'b1);
    @(posedge clk);
    check(16'(tx_offer), (pb > pa) ? 16'h3 : 16'h2);
    rchk(addr_ctrl_base + 5'h1, {ctl(1, 0, 1, pb), ctl(1, 0, 1, pa)});
    outcome <= 2'h1;
    wait_pend(1'b0);
    outcome <= 2'h0;
    rchk(addr_ctrl_base + 5'h1, {ctl(1, 0, 0, pb), ctl(1, 0, 0, pa)});
    $display("priority test done");
    for (int k = 2; k < 4; k++) begin
      st = (k == 2) ? 8'h20 : 8'h10;
      wreg(addr_ctrl_base, {8'h00, ctl(1, 0, 1, 2'h0)});
      wait_pend(1'b1);
      outcome <= 2'(k);
      repeat (12) @(posedge clk);
      outcome <= 2'h0;
      rchk(addr_ctrl_base, {8'h00, ctl(1, 0, 1, 2'h0) | st});
      wreg(addr_ctrl_base, {8'h00, ctl(1, 0, 0, 2'h0)});
      wait_pend(1'b0);
      rchk(addr_ctrl_base, {8'h00, ctl(1, 0, 0, 2'h0) | st | 8'h40});
    end
    $display("abort test done");
    wreg(addr_ctrl_base + 5'h2, {ctl(1, 0, 0, 2'h0), ctl(1, 1, 0, 2'h0)});
    ev(1'b1, 5'h05);
    ev(1'b1, 5'h04);
    rchk(addr_ctrl_base + 5'h2, {ctl(1, 0, 0, 2'h0), ctl(1, 1, 1, 2'h0)});
    rchk(addr_offer, 16'h000c);
    v = 16'($urandom_range(31));
    wreg(addr_id_port, v);
    rchk(addr_id_port, v);
    wreg(addr_id_data, 16'hffff);
    rchk(addr_id_data, 16'h0000);
    $display("remote test done");
    rchk(5'h1f, 16'h0000);
    $display("unmapped test done");
    complete_run();
  end
endmodule
